// >>> tcm_top.sv
// Our own choices: the APB slave port and the address map.
`include "tcm_defs.svh"
module tcm_top (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Crystal clock pin and sleep state.
  input wire logic crystal_clock_input,
  input wire logic deep_sleep,
  output logic osc_run,
  // Waveform outputs and the two port pins they may override.
  output logic [1:0] waveform_output,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  // Flag levels for the interrupt controller outside.
  output logic compare_flag_a,
  output logic compare_flag_b,
  output logic overflow_flag
);
  tcm_pkg::tcm_top_state_t st_q, st_d;
  tcm_pkg::tcm_mode_t mode;
  logic [2:0] waveform_gen_select;
  logic [7:0] top_val;
  logic xtal_rise;
  logic timer_clock_enable;
  logic wr_en;
  logic setup;
  logic [1:0] match;
  logic [1:0] com [2];

  tcm_ch_if ch_if[2] ();

  // Crystal edges are filtered on the bus clock.
  tcm_xtal_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(crystal_clock_input),
    .rise(xtal_rise)
  );

  assign waveform_gen_select = {st_q.ctl_b[`TCM_WGM2_BIT], st_q.ctl_a[1:0]};
  assign com[0] = st_q.ctl_a[`TCM_COM_A_LO+1:`TCM_COM_A_LO];
  assign com[1] = st_q.ctl_a[`TCM_COM_B_LO+1:`TCM_COM_B_LO];

  // The timer clock is an enable on pclk; in async it is the crystal edge.
  assign timer_clock_enable = st_q.ctl_b[`TCM_RUN_BIT] &
    (st_q.async_sel ? xtal_rise : 1'b1);

  // Reserved encodings fall back to normal counting.
  always_comb
  begin
    case (waveform_gen_select)
      3'd1, 3'd5: mode = tcm_pkg::tcm_mode_phase;
      3'd2: mode = tcm_pkg::tcm_mode_ctc;
      3'd3, 3'd7: mode = tcm_pkg::tcm_mode_fast;
      default: mode = tcm_pkg::tcm_mode_normal;
    endcase
  end

  // Top comes from compare A in CTC and in the PWM modes with bit two set.
  always_comb
  begin
    if ((mode == tcm_pkg::tcm_mode_ctc) ||
        (waveform_gen_select[2] && mode[1]))
      top_val = ch_if[0].cmp_act;
    else
      top_val = `TCM_CNT_MAX;
  end

  // Both channels share the counter and differ in compare and mode bits.
  for (genvar g = 0; g < 2; g++)
  begin : gen_ch
    assign ch_if[g].tick = timer_clock_enable;
    assign ch_if[g].cmp_en = ~st_q.block & ~st_q.busy[`TCM_H_CNT] &
      ~st_q.busy[`TCM_H_CMP_A - g];
    assign ch_if[g].force_p = st_q.force_p[g];
    assign ch_if[g].at_top = (st_q.cnt == top_val);
    assign ch_if[g].at_bottom = (st_q.cnt == `TCM_CNT_BOTTOM);
    assign ch_if[g].down = st_q.down;
    assign ch_if[g].wgm2 = waveform_gen_select[2];
    assign ch_if[g].mode = mode;
    assign ch_if[g].com = com[g];
    assign ch_if[g].count = st_q.cnt;
    assign ch_if[g].cmp_buf = st_q.cmp[g];
    assign match[g] = ch_if[g].match;
    assign waveform_output[g] = ch_if[g].wave;
    // The port keeps the direction; only the data source is swapped.
    assign pin_out[g] = (com[g] != 2'b00) ? ch_if[g].wave :
      st_q.port_data[g];
    assign pin_oe[g] = st_q.port_dir[g];
    tcm_wave_ch u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .ch(ch_if[g].ch)
    );
  end

  // Loads one destination register; shared by direct and held writes.
  function automatic tcm_pkg::tcm_top_state_t put_reg(
    input tcm_pkg::tcm_top_state_t s, input int idx, input logic [7:0] v);
    tcm_pkg::tcm_top_state_t r;
    r = s;
    case (idx)
      `TCM_H_CNT:
      begin
        r.cnt = v;
        r.block = 1'b1;
      end
      `TCM_H_CMP_A: r.cmp[0] = v;
      `TCM_H_CMP_B: r.cmp[1] = v;
      `TCM_H_CTL_A: r.ctl_a = v;
      `TCM_H_CTL_B:
      begin
        r.ctl_b = v & `TCM_CTL_B_MASK;
        r.force_p = {v[`TCM_FOC_B_BIT], v[`TCM_FOC_A_BIT]};
      end
      default: r = s;
    endcase
    return r;
  endfunction

  // Maps a bus offset to its holding register, or minus one.
  function automatic int hold_idx(input logic [7:0] a);
    case (a)
      `TCM_OFF_CNT: hold_idx = `TCM_H_CNT;
      `TCM_OFF_CMP_A: hold_idx = `TCM_H_CMP_A;
      `TCM_OFF_CMP_B: hold_idx = `TCM_H_CMP_B;
      `TCM_OFF_CTL_A: hold_idx = `TCM_H_CTL_A;
      `TCM_OFF_CTL_B: hold_idx = `TCM_H_CTL_B;
      default: hold_idx = -1;
    endcase
  endfunction

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;

  // Next state: counting, flags, async transfers, then bus writes last so
  // that a count write wins over the tick in the same cycle.
  always_comb
  begin
    int hi;
    logic [2:0] set_ev;
    logic [2:0] clr;
    hi = hold_idx(paddr);
    set_ev = 3'b000;
    clr = 3'b000;
    st_d = st_q;
    st_d.force_p = 2'b00;

    // Counter; the block flag lasts through exactly one timer tick.
    if (timer_clock_enable)
    begin
      st_d.block = 1'b0;
      case (mode)
        tcm_pkg::tcm_mode_normal:
        begin
          st_d.cnt = st_q.cnt + 8'h01;
          set_ev[2] = (st_q.cnt == `TCM_CNT_MAX);
        end
        tcm_pkg::tcm_mode_ctc, tcm_pkg::tcm_mode_fast:
        begin
          st_d.cnt = (st_q.cnt == top_val) ? `TCM_CNT_BOTTOM :
            st_q.cnt + 8'h01;
          set_ev[2] = (mode == tcm_pkg::tcm_mode_ctc) ?
            (st_q.cnt == `TCM_CNT_MAX) : (st_q.cnt == top_val);
        end
        tcm_pkg::tcm_mode_phase:
        begin
          if (!st_q.down && (st_q.cnt == top_val))
          begin
            st_d.down = 1'b1;
            st_d.cnt = st_q.cnt - 8'h01;
          end
          else if (st_q.down && (st_q.cnt == `TCM_CNT_BOTTOM))
          begin
            st_d.down = 1'b0;
            st_d.cnt = st_q.cnt + 8'h01;
            set_ev[2] = 1'b1;
          end
          else
            st_d.cnt = st_q.down ? st_q.cnt - 8'h01 : st_q.cnt + 8'h01;
        end
        default: st_d.cnt = st_q.cnt;
      endcase
    end

    // Only real matches reach the compare flags, never a forced one.
    set_ev[1:0] = match;

    // After a clear in async mode flags wait for one crystal edge.
    if (xtal_rise || !st_q.async_sel)
      st_d.rearm = 1'b1;
    if (wr_en && (paddr == `TCM_OFF_FLAG))
    begin
      clr = pwdata[2:0];
      if (st_q.async_sel && (clr != 3'b000))
        st_d.rearm = 1'b0;
    end
    // A set in the same cycle as its clear wins.
    st_d.flags = (st_q.flags & ~clr) | (set_ev & {3{st_q.rearm}});

    // Each holding register counts crystal edges on its own.
    for (int i = 0; i < `TCM_NUM_HOLD; i++)
    begin
      if (st_q.busy[i] && xtal_rise)
      begin
        if (st_q.edges[i] == `TCM_XFER_LAST)
        begin
          st_d = put_reg(st_d, i, st_q.hold[i]);
          st_d.busy[i] = 1'b0;
          st_d.edges[i] = 2'b00;
        end
        else
          st_d.edges[i] = st_q.edges[i] + 2'b01;
      end
    end

    // Bus writes take effect at the access edge; in async mode register writes go to a holding register instead.
    if (wr_en)
    begin
      if (hi >= 0)
      begin
        if (st_q.async_sel)
        begin
          st_d.hold[hi] = pwdata[7:0];
          st_d.busy[hi] = 1'b1;
          st_d.edges[hi] = 2'b00;
        end
        else
          st_d = put_reg(st_d, hi, pwdata[7:0]);
      end
      else if (paddr == `TCM_OFF_STAT)
        st_d.async_sel = pwdata[`TCM_ASYNC_BIT];
      else if (paddr == `TCM_OFF_PORT)
      begin
        st_d.port_data = pwdata[1:0];
        st_d.port_dir = pwdata[`TCM_DIR_LO+1:`TCM_DIR_LO];
      end
    end

    // Read data and error are captured in the setup cycle.
    if (setup)
    begin
      st_d.pslverr = 1'b0;
      case (paddr)
        `TCM_OFF_CTL_A: st_d.prdata = {24'h00_0000, st_q.ctl_a};
        `TCM_OFF_CTL_B: st_d.prdata = {24'h00_0000, st_q.ctl_b};
        `TCM_OFF_CNT: st_d.prdata = {24'h00_0000, st_q.cnt};
        `TCM_OFF_CMP_A: st_d.prdata = {24'h00_0000, st_q.cmp[0]};
        `TCM_OFF_CMP_B: st_d.prdata = {24'h00_0000, st_q.cmp[1]};
        `TCM_OFF_STAT:
          st_d.prdata = {26'h00_0000, st_q.async_sel, st_q.busy};
        `TCM_OFF_FLAG: st_d.prdata = {29'h000_0000, st_q.flags};
        `TCM_OFF_PORT:
          st_d.prdata = {26'h00_0000, st_q.port_dir, 2'b00,
            st_q.port_data};
        default:
        begin
          st_d.prdata = 32'h0000_0000;
          st_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Zero wait states: the answer was prepared during setup.
  assign pready = 1'b1;
  assign prdata = st_q.prdata;
  assign pslverr = st_q.pslverr & psel & penable;

  // The crystal oscillator runs only in async mode and stops in the deepest sleep states.
  assign osc_run = st_q.async_sel & ~deep_sleep;
  assign compare_flag_a = st_q.flags[0];
  assign compare_flag_b = st_q.flags[1];
  assign overflow_flag = st_q.flags[2];
endmodule

// >>> tcm_defs.svh
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH
`define TCM_OFF_CTL_A 8'h00
`define TCM_OFF_CTL_B 8'h04
`define TCM_OFF_CNT 8'h08
`define TCM_OFF_CMP_A 8'h0c
`define TCM_OFF_CMP_B 8'h10
`define TCM_OFF_STAT 8'h14
`define TCM_OFF_FLAG 8'h18
`define TCM_OFF_PORT 8'h1c
`define TCM_COM_A_LO 6
`define TCM_COM_B_LO 4
`define TCM_FOC_A_BIT 7
`define TCM_FOC_B_BIT 6
`define TCM_WGM2_BIT 3
`define TCM_RUN_BIT 0
`define TCM_CTL_B_MASK 8'h09
`define TCM_ASYNC_BIT 5
`define TCM_DIR_LO 4
`define TCM_H_CTL_B 0
`define TCM_H_CTL_A 1
`define TCM_H_CMP_B 2
`define TCM_H_CMP_A 3
`define TCM_H_CNT 4
`define TCM_NUM_HOLD 5
`define TCM_XFER_LAST 2'd1
`define TCM_RST_BYTE 8'h00
`define TCM_CNT_MAX 8'hff
`define TCM_CNT_BOTTOM 8'h00
`endif

// >>> tcm_pkg.sv
`include "tcm_defs.svh"
package tcm_pkg;
  typedef enum logic [1:0] {
    tcm_mode_normal = 2'b00,
    tcm_mode_ctc = 2'b01,
    tcm_mode_fast = 2'b10,
    tcm_mode_phase = 2'b11
  } tcm_mode_t;

  typedef struct packed {
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] cnt;
    logic [1:0][7:0] cmp;
    logic async_sel;
    logic [1:0] port_data;
    logic [1:0] port_dir;
    logic [2:0] flags;
    logic [`TCM_NUM_HOLD-1:0][7:0] hold;
    logic [`TCM_NUM_HOLD-1:0][1:0] edges;
    logic [`TCM_NUM_HOLD-1:0] busy;
    logic block;
    logic down;
    logic rearm;
    logic [1:0] force_p;
    logic [31:0] prdata;
    logic pslverr;
  } tcm_top_state_t;

  typedef struct packed {
    logic wave;
    logic [7:0] cmp_act;
    logic match;
  } tcm_ch_state_t;

  typedef struct packed {
    logic [2:0] stage;
    logic level;
    logic rise;
  } tcm_sync_state_t;
endpackage

// >>> tcm_ch_if.sv
interface tcm_ch_if;
  logic tick;
  logic cmp_en;
  logic force_p;
  logic at_top;
  logic at_bottom;
  logic down;
  logic wgm2;
  tcm_pkg::tcm_mode_t mode;
  logic [1:0] com;
  logic [7:0] count;
  logic [7:0] cmp_buf;
  logic wave;
  logic match;
  logic [7:0] cmp_act;
  modport top (output tick, cmp_en, force_p, at_top, at_bottom, down,
    wgm2, mode, com, count, cmp_buf, input wave, match, cmp_act);
  modport ch (input tick, cmp_en, force_p, at_top, at_bottom, down,
    wgm2, mode, com, count, cmp_buf, output wave, match, cmp_act);
endinterface

// >>> tcm_xtal_sync.sv
module tcm_xtal_sync (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Crystal pin and its filtered rising edge.
  input wire logic pin,
  output logic rise
);
  tcm_pkg::tcm_sync_state_t st_q, st_d;

  // A change counts only once the second and third stages agree.
  always_comb
  begin
    st_d = st_q;
    st_d.stage = {st_q.stage[1:0], pin};
    st_d.rise = 1'b0;
    if (st_q.stage[1] == st_q.stage[2])
    begin
      st_d.level = st_q.stage[2];
      st_d.rise = st_q.stage[2] & ~st_q.level;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rise = st_q.rise;
endmodule

// >>> tcm_wave_ch.sv
module tcm_wave_ch (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link to the timer core.
  tcm_ch_if.ch ch
);
  tcm_pkg::tcm_ch_state_t st_q, st_d;
  logic hit;
  logic pwm;

  assign hit = ch.tick & ch.cmp_en & (ch.count == st_q.cmp_act);
  assign pwm = ch.mode[1];

  // The waveform flop is never reset by a mode change, only by actions.
  always_comb
  begin
    st_d = st_q;
    st_d.match = hit;
    if (!pwm)
      st_d.cmp_act = ch.cmp_buf;
    else if (ch.tick & ch.at_top)
      st_d.cmp_act = ch.cmp_buf;
    case (ch.mode)
      tcm_pkg::tcm_mode_normal, tcm_pkg::tcm_mode_ctc:
      begin
        // Force acts like a match here but never reaches the flag.
        if (hit | ch.force_p)
        begin
          case (ch.com)
            2'b01: st_d.wave = ~st_q.wave;
            2'b10: st_d.wave = 1'b0;
            2'b11: st_d.wave = 1'b1;
            default: st_d.wave = st_q.wave;
          endcase
        end
      end
      tcm_pkg::tcm_mode_fast:
      begin
        if (hit)
        begin
          case (ch.com)
            2'b01: st_d.wave = ch.wgm2 ? ~st_q.wave : st_q.wave;
            2'b10: st_d.wave = 1'b0;
            2'b11: st_d.wave = 1'b1;
            default: st_d.wave = st_q.wave;
          endcase
        end
        else if (ch.tick & ch.at_bottom & ch.com[1])
          st_d.wave = ~ch.com[0];
      end
      tcm_pkg::tcm_mode_phase:
      begin
        if (hit)
        begin
          case (ch.com)
            2'b01: st_d.wave = ch.wgm2 ? ~st_q.wave : st_q.wave;
            2'b10: st_d.wave = ch.down;
            2'b11: st_d.wave = ~ch.down;
            default: st_d.wave = st_q.wave;
          endcase
        end
      end
      default: st_d.wave = st_q.wave;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign ch.wave = st_q.wave;
  assign ch.match = st_q.match;
  assign ch.cmp_act = st_q.cmp_act;
endmodule

// >>> tcm_pin_env.sv
module tcm_pin_env #(
  parameter time XT_HALF = 50ns
) (
  // Oscillator request from the timer.
  input logic osc_run,
  // Port pins as driven by the block.
  input logic [1:0] pin_out,
  input logic [1:0] pin_oe,
  // Crystal clock and resolved pad levels.
  output logic xtal,
  output logic [1:0] pad
);
  timeunit 1ns;
  timeprecision 100ps;
  // The crystal starts a half period only while the block asks for it; a half
  // period already begun still ends in an edge after osc_run falls.
  // A 100 ns period keeps the bus clock twenty times faster.
  initial xtal = 1'h0;
  always
  begin
    wait (osc_run);
    #XT_HALF;
    xtal = ~xtal;
  end
  // Undriven pads float up to the pull-up level.
  assign pad[0] = pin_oe[0] ? pin_out[0] : 1'h1;
  assign pad[1] = pin_oe[1] ? pin_out[1] : 1'h1;
endmodule

// >>> tcm_top_chk.sv
module tcm_top_chk (
  // Clock and reset.
  input logic pclk,
  input logic presetn,
  // Register bus.
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  // Oscillator, pins and flag.
  input logic deep_sleep,
  input logic osc_run,
  input logic [1:0] waveform_output,
  input logic [1:0] pin_out,
  input logic [1:0] pin_oe,
  input logic compare_flag_a
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wr;
  logic as_q;
  logic [1:0] dir_q;
  logic [7:0] ctl_q;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadows of the steering registers; async control writes land late in
  // the design, so the pin routing checks only hold while the shadow says sync.
  assign wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_q <= 8'h00;
      dir_q <= 2'h0;
      as_q <= 1'h0;
    end
    else if (wr)
    begin
      if (paddr == 8'h00) ctl_q <= pwdata[7:0];
      if (paddr == 8'h14) as_q <= pwdata[5];
      if (paddr == 8'h1c) dir_q <= pwdata[5:4];
    end
  end
  // A force write on channel A in a non-PWM mode, sync clocking.
  sequence s_force_a;
    wr && paddr == 8'h04 && pwdata[7] && !ctl_q[0] && !as_q;
  endsequence
  sequence s_idle_a;
    (!as_q && ctl_q[7:6] == 2'h0) [*4];
  endsequence
  property p_ready;
    psel && penable |-> pready;
  endproperty
  property p_unmapped;
    psel && penable && paddr > 8'h1c |-> pslverr;
  endproperty
  property p_dir;
    pin_oe == dir_q;
  endproperty
  property p_route_a;
    !as_q && ctl_q[7:6] != 2'h0 |-> pin_out[0] == waveform_output[0];
  endproperty
  property p_route_b;
    !as_q && ctl_q[5:4] != 2'h0 |-> pin_out[1] == waveform_output[1];
  endproperty
  property p_osc;
    osc_run == (as_q && !deep_sleep);
  endproperty
  property p_idle_a;
    s_idle_a |-> $stable(waveform_output[0]);
  endproperty
  property p_force_set;
    s_force_a ##0 ctl_q[7:6] == 2'h3 |-> ##[1:3] waveform_output[0];
  endproperty
  property p_force_clr;
    s_force_a ##0 ctl_q[7:6] == 2'h2 |-> ##[1:3] !waveform_output[0];
  endproperty
  property p_force_flag;
    s_force_a ##0 !pwdata[0] |=> (!$rose(compare_flag_a)) [*3];
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  a_dir: assert property (p_dir) else $error("enable off");
  a_route_a: assert property (p_route_a) else $error("pin A");
  a_route_b: assert property (p_route_b) else $error("pin B");
  a_osc: assert property (p_osc) else $error("oscillator");
  a_idle_a: assert property (p_idle_a) else $error("idle acted");
  a_force_set: assert property (p_force_set) else $error("no set");
  a_force_clr: assert property (p_force_clr) else $error("no clr");
  a_force_flag: assert property (p_force_flag) else $error("flag");
endmodule
bind tcm_top tcm_top_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .deep_sleep, .osc_run,
  .waveform_output, .pin_out, .pin_oe, .compare_flag_a);

// >>> test_timer_compare_output_async_update.sv
module test_timer_compare_output_async_update;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] WAVE_EXP = 4'hd;
  localparam logic [3:0] PAD_EXP = 4'h5;
  logic pclk, presetn, psel, penable, pwrite, deep_sleep, xtal;
  logic pready, pslverr, osc_run, flag_a, flag_b, ovf, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] wave, pin_out, pin_oe, pad;
  int bad_count, comparisons;
  tcm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock_input(xtal), .deep_sleep(deep_sleep), .osc_run(osc_run),
    .waveform_output(wave), .pin_out(pin_out), .pin_oe(pin_oe),
    .compare_flag_a(flag_a), .compare_flag_b(flag_b), .overflow_flag(ovf));
  tcm_pin_env env (.osc_run(osc_run), .pin_out(pin_out), .pin_oe(pin_oe),
    .xtal(xtal), .pad(pad));
  // Bus clock, 5 ns period.
  initial
  begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  // Compare one value and keep the tallies.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus transfer; the wait is bounded so a dead slave cannot hang us.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n >= 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog well past the few hundred cycles the sequence needs.
  initial
  begin
    #20us;
    bad_count++;
    summarize();
  end
  initial
  begin
    int i;
    {psel, penable, pwrite, deep_sleep} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bad_count = 0;
    comparisons = 0;
    presetn = 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values, then an unmapped place answers zero with an error.
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h14, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    check(err, 1'h1);
    // Drive pin A out, then force each mode: set, clear, toggle, none.
    xfer(1'h1, 8'h1c, 32'h0000_0010);
    @(posedge pclk);
    check(pin_oe, 2'h1);
    for (i = 0; i < 4; i++)
    begin
      xfer(1'h1, 8'h00, {24'h0, 2'(3 - i), 6'h00});
      xfer(1'h1, 8'h04, 32'h0000_0080);
      repeat (3) @(posedge pclk);
      check(wave[0], WAVE_EXP[i]);
      check(pad[0], PAD_EXP[i]);
    end
    rchk(8'h04, 32'h0000_0000);
    // Channel B set by its own strobe.
    xfer(1'h1, 8'h00, 32'h0000_0030);
    xfer(1'h1, 8'h04, 32'h0000_0040);
    repeat (3) @(posedge pclk);
    check(wave[1], 1'h1);
    // Fast PWM keeps the state and ignores a force.
    xfer(1'h1, 8'h00, 32'h0000_0083);
    xfer(1'h1, 8'h04, 32'h0000_0080);
    repeat (3) @(posedge pclk);
    check(wave[0], 1'h1);
    check(wave[0], 1'h1);
    // Phase correct PWM behaves the same way.
    xfer(1'h1, 8'h00, 32'h0000_0081);
    xfer(1'h1, 8'h04, 32'h0000_0080);
    repeat (3) @(posedge pclk);
    check(wave[0], 1'h1);
    // CTC is a non-PWM mode, so a force with clear mode drops the state.
    xfer(1'h1, 8'h00, 32'h0000_0082);
    xfer(1'h1, 8'h04, 32'h0000_0080);
    repeat (3) @(posedge pclk);
    check(wave[0], 1'h0);
    // Pin turned to input hides the waveform behind the pull-up.
    xfer(1'h1, 8'h1c, 32'h0000_0001);
    @(posedge pclk);
    check(pin_oe, 2'h0);
    check(pad[0], 1'h1);
    // Count loaded equal to compare: first pass blocked, wrap matches.
    xfer(1'h1, 8'h00, 32'h0000_0040);
    xfer(1'h1, 8'h0c, 32'h0000_0010);
    xfer(1'h1, 8'h08, 32'h0000_0010);
    xfer(1'h1, 8'h04, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    check(flag_a, 1'h0);
    check(wave[0], 1'h0);
    repeat (260) @(posedge pclk);
    check(flag_a, 1'h1);
    check(wave[0], 1'h1);
    check(flag_b, 1'h1);
    check(ovf, 1'h1);
    xfer(1'h1, 8'h04, 32'h0000_0000);
    xfer(1'h1, 8'h18, 32'h0000_0007);
    rchk(8'h18, 32'h0000_0000);
    // Go asynchronous; deep sleep stops the oscillator.
    xfer(1'h1, 8'h14, 32'h0000_0020);
    @(posedge pclk);
    check(osc_run, 1'h1);
    // Sleep is entered with no update pending.
    deep_sleep <= 1'h1;
    @(posedge pclk);
    check(osc_run, 1'h0);
    deep_sleep <= 1'h0;
    // Two holding registers in flight at once, each written only once.
    // A scaled stability wait: the first crystal edge after wake-up.
    @(posedge xtal);
    repeat (5) @(posedge pclk);
    xfer(1'h1, 8'h10, 32'h0000_005a);
    // The count differs from both compare values, so no match is lost.
    xfer(1'h1, 8'h08, 32'h0000_0033);
    rchk(8'h14, 32'h0000_0034);
    @(posedge xtal);
    repeat (6) @(posedge pclk);
    rchk(8'h14, 32'h0000_0034);
    @(posedge xtal);
    repeat (6) @(posedge pclk);
    rchk(8'h14, 32'h0000_0020);
    rchk(8'h10, 32'h0000_005a);
    rchk(8'h08, 32'h0000_0033);
    summarize();
  end
endmodule
